// File: shared/timer_channel_pkg.sv
package timer_channel_pkg;

    // register byte addresses, one aligned word each
    localparam logic [7:0]  OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0]  OFS_VALUE_HIGH     = 8'h04;
    localparam logic [7:0]  OFS_VALUE_LOW      = 8'h08;

    // channel_status_control field positions
    localparam int unsigned SC_FLAG_BIT        = 7;
    localparam int unsigned SC_MODE_B_BIT      = 5;
    localparam int unsigned SC_MODE_A_BIT      = 4;
    localparam int unsigned SC_ELS_HI_BIT      = 3;
    localparam int unsigned SC_ELS_LO_BIT      = 2;
    localparam logic [7:0]  SC_WRITE_MASK      = 8'h7c;

    localparam logic [7:0]  SC_RESET           = 8'h00;
    localparam logic [15:0] VALUE_RESET        = 16'h0000;
    localparam logic [15:0] FREE_RUN_TOP       = 16'hffff;
    localparam logic [15:0] MODULO_NONE        = 16'h0000;
    localparam logic [1:0]  CLK_NONE           = 2'h0;

    localparam logic [1:0]  ELS_OFF            = 2'h0;
    localparam logic [1:0]  ELS_01             = 2'h1;
    localparam logic [1:0]  ELS_10             = 2'h2;
    localparam logic [1:0]  ELS_11             = 2'h3;

    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_ALIGNED_PWM,
        MODE_CENTER_ALIGNED_PWM
    } chan_mode_e;

    function automatic chan_mode_e chan_mode(input logic cas, input logic [7:0] sc);
        if (cas)
            return MODE_CENTER_ALIGNED_PWM;
        else if (sc[SC_MODE_B_BIT])
            return MODE_EDGE_ALIGNED_PWM;
        else if (sc[SC_MODE_A_BIT])
            return MODE_COMPARE;
        else
            return MODE_CAPTURE;
    endfunction

endpackage

// File: design/pin_edge_sync.sv
module pin_edge_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_raw,
    output logic      rise,
    output logic      fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a new level counts only once the second and third stages agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= 1'b0;
            rise    <= 1'b0;
            fall    <= 1'b0;
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (s2_q == s3_q && s3_q != level_q) begin
                level_q <= s3_q;
                rise    <= s3_q;
                fall    <= !s3_q;
            end
        end
    end
endmodule // pin_edge_sync

// File: design/timer_channel.sv
// What this block does
// - without centre mode and mode B clear, mode A picks capture or compare
// - edge/level select 00 releases the pin from every timer function
// - capture edge: 01 rising, 10 falling, 11 either edge
// - compare match: 01 toggles pin, 10 drives low, 11 drives high
// - without centre mode, mode B set gives edge PWM: 10 high-true cleared, x1 low-true set
// - centre mode gives centre PWM, 10 clears and x1 sets on up-compare
// - value register holds capture or compare value, reset to zero
// - in capture, a byte read freezes both bytes until the other is read
// - status/control write releases the read latch, even in debug
// - value writes are discarded while in capture mode
// - in debug, read latch frozen and reads return live contents
// - compare writes are buffered; no clock means load on second byte
// - compare with clock loads buffer at next counter step
// - PWM with clock loads buffer when counter reaches modulo or 0xffff
// - status/control write restarts the write buffer sequence
// - the two bytes may arrive in either order
// - in debug, value writes go straight into the register
// - debug writes leave a partial buffered sequence intact
// - flag sets on capture edge or on counter match
// - clock select 00 means no counter clock
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
module timer_channel #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic [15:0]       counter_value,
    input  wire logic              counter_step,
    input  wire logic              count_up,
    input  wire logic [1:0]        clock_select,
    input  wire logic [15:0]       modulo_value,
    input  wire logic              center_aligned_select,
    input  wire logic              background_debug_mode,
    input  wire logic              chan_pin_in,
    output logic                   chan_pin_out,
    output logic                   chan_pin_oe,
    output logic                   channel_event_flag
);
    logic [7:0]        sc_q;
    logic [15:0]       value_q;
    logic [15:0]       wbuf_q;
    logic [15:0]       wbuf_d;
    logic [15:0]       rd_buf_q;
    logic              wr_hi_seen_q;
    logic              wr_lo_seen_q;
    logic              xfer_pend_q;
    logic              rd_latched_q;
    logic              rd_first_hi_q;
    logic              flag_armed_q;
    logic              wr_pend_q;
    logic [7:0]        wr_addr_q;
    logic              pin_rise;
    logic              pin_fall;
    timer_channel_pkg::chan_mode_e mode;
    logic [1:0]        els;
    logic              acc;
    logic [7:0]        acc_addr;
    logic              rd_sc;
    logic              rd_val;
    logic              rd_is_hi;
    logic              wr_sc;
    logic              wr_vh;
    logic              wr_vl;
    logic              wr_val;
    logic              debug;
    logic              buf_wr;
    logic              seq_done;
    logic              clk_on;
    logic [15:0]       counter_top;
    logic              match;
    logic              xfer_now;
    logic              cap_edge;
    logic              event_hit;
    logic [15:0]       rd_view;

    pin_edge_sync u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_raw (chan_pin_in),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    assign mode     = timer_channel_pkg::chan_mode(center_aligned_select, sc_q);
    assign els      = sc_q[timer_channel_pkg::SC_ELS_HI_BIT:timer_channel_pkg::SC_ELS_LO_BIT];
    assign debug    = background_debug_mode;
    assign acc      = hsel && htrans[1] && hready;
    assign acc_addr = haddr[7:0];
    assign rd_sc    = acc && !hwrite && acc_addr == timer_channel_pkg::OFS_STATUS_CONTROL;
    assign rd_is_hi = acc_addr == timer_channel_pkg::OFS_VALUE_HIGH;
    assign rd_val   = acc && !hwrite && (rd_is_hi || acc_addr == timer_channel_pkg::OFS_VALUE_LOW);
    assign wr_sc    = wr_pend_q && wr_addr_q == timer_channel_pkg::OFS_STATUS_CONTROL;
    assign wr_vh    = wr_pend_q && wr_addr_q == timer_channel_pkg::OFS_VALUE_HIGH;
    assign wr_vl    = wr_pend_q && wr_addr_q == timer_channel_pkg::OFS_VALUE_LOW;
    assign wr_val   = (wr_vh || wr_vl) && mode != timer_channel_pkg::MODE_CAPTURE;

    assign clk_on   = clock_select != timer_channel_pkg::CLK_NONE;
    assign counter_top = (modulo_value == timer_channel_pkg::MODULO_NONE) ?
                         timer_channel_pkg::FREE_RUN_TOP : modulo_value;

    // byte merge into the write buffer, either order
    assign wbuf_d   = {wr_vh ? hwdata[7:0] : wbuf_q[15:8],
                       wr_vl ? hwdata[7:0] : wbuf_q[7:0]};
    assign buf_wr   = wr_val && !debug;
    assign seq_done = buf_wr && (wr_vh || wr_hi_seen_q) && (wr_vl || wr_lo_seen_q);

    // counter_step marks the first cycle that counter_value shows a new count
    assign match    = clk_on && counter_step && counter_value == value_q &&
                      mode != timer_channel_pkg::MODE_CAPTURE;
    assign xfer_now = xfer_pend_q && counter_step && mode != timer_channel_pkg::MODE_CAPTURE &&
                      (mode == timer_channel_pkg::MODE_COMPARE || counter_value == counter_top);
    // edges seen while the pin settles into capture are not filtered
    assign cap_edge = mode == timer_channel_pkg::MODE_CAPTURE &&
                      ((els[0] && pin_rise) || (els[1] && pin_fall));
    assign event_hit = cap_edge || match;

    // bus write data arrives one cycle after its address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            if (acc && hwrite)
                wr_addr_q <= acc_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sc_q <= timer_channel_pkg::SC_RESET;
        end else begin
            if (wr_sc)
                sc_q[6:0] <= (hwdata[6:0] & timer_channel_pkg::SC_WRITE_MASK[6:0]);
            // a new event beats a clear in the same cycle
            if (event_hit)
                sc_q[timer_channel_pkg::SC_FLAG_BIT] <= 1'b1;
            else if (wr_sc && !hwdata[timer_channel_pkg::SC_FLAG_BIT] && flag_armed_q)
                sc_q[timer_channel_pkg::SC_FLAG_BIT] <= 1'b0;
        end
    end

    // the clear needs a read of the flag set first; any new event restarts it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            flag_armed_q <= 1'b0;
        else if (event_hit)
            flag_armed_q <= 1'b0;
        else if (rd_sc && sc_q[timer_channel_pkg::SC_FLAG_BIT])
            flag_armed_q <= 1'b1;
        else if (wr_sc)
            flag_armed_q <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_q <= timer_channel_pkg::VALUE_RESET;
        end else if (cap_edge) begin
            value_q <= counter_value;
        end else if (wr_val && debug) begin
            if (wr_vh)
                value_q[15:8] <= hwdata[7:0];
            if (wr_vl)
                value_q[7:0] <= hwdata[7:0];
        end else if (seq_done && !clk_on) begin
            value_q <= wbuf_d;
        end else if (xfer_now) begin
            value_q <= wbuf_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wbuf_q <= timer_channel_pkg::VALUE_RESET;
        else if (buf_wr)
            wbuf_q <= wbuf_d;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_hi_seen_q <= 1'b0;
            wr_lo_seen_q <= 1'b0;
            xfer_pend_q  <= 1'b0;
        end else if (wr_sc) begin
            wr_hi_seen_q <= 1'b0;
            wr_lo_seen_q <= 1'b0;
            xfer_pend_q  <= 1'b0;
        end else begin
            if (seq_done) begin
                wr_hi_seen_q <= 1'b0;
                wr_lo_seen_q <= 1'b0;
            end else if (buf_wr) begin
                wr_hi_seen_q <= wr_hi_seen_q || wr_vh;
                wr_lo_seen_q <= wr_lo_seen_q || wr_vl;
            end
            if (seq_done && clk_on)
                xfer_pend_q <= 1'b1;
            else if (xfer_now)
                xfer_pend_q <= 1'b0;
        end
    end

    // reads act in the address phase so hrdata can come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_latched_q  <= 1'b0;
            rd_first_hi_q <= 1'b0;
            rd_buf_q      <= timer_channel_pkg::VALUE_RESET;
        end else if (wr_sc) begin
            rd_latched_q <= 1'b0;
        end else if (rd_val && !debug && mode == timer_channel_pkg::MODE_CAPTURE) begin
            if (!rd_latched_q) begin
                rd_latched_q  <= 1'b1;
                rd_first_hi_q <= rd_is_hi;
                rd_buf_q      <= value_q;
            end else if (rd_is_hi != rd_first_hi_q) begin
                rd_latched_q <= 1'b0;
            end
        end
    end

    assign rd_view = (rd_latched_q && !debug && mode == timer_channel_pkg::MODE_CAPTURE) ?
                     rd_buf_q : value_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (acc && !hwrite) begin
                case (acc_addr)
                    timer_channel_pkg::OFS_STATUS_CONTROL: hrdata <= {24'h000000, sc_q[7:2], 2'h0};
                    timer_channel_pkg::OFS_VALUE_HIGH:     hrdata <= {24'h000000, rd_view[15:8]};
                    timer_channel_pkg::OFS_VALUE_LOW:      hrdata <= {24'h000000, rd_view[7:0]};
                    default:                               hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            chan_pin_oe <= 1'b0;
        else
            chan_pin_oe <= els != timer_channel_pkg::ELS_OFF &&
                           mode != timer_channel_pkg::MODE_CAPTURE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_pin_out <= 1'b0;
        end else if (els == timer_channel_pkg::ELS_OFF) begin
            chan_pin_out <= 1'b0;
        end else begin
            case (mode)
                timer_channel_pkg::MODE_COMPARE: begin
                    if (match) begin
                        case (els)
                            timer_channel_pkg::ELS_01: chan_pin_out <= !chan_pin_out;
                            timer_channel_pkg::ELS_10: chan_pin_out <= 1'b0;
                            default:                   chan_pin_out <= 1'b1;
                        endcase
                    end
                end
                timer_channel_pkg::MODE_EDGE_ALIGNED_PWM: begin
                    // match after period start wins, so value zero gives 0% duty
                    if (match)
                        chan_pin_out <= els != timer_channel_pkg::ELS_10;
                    else if (clk_on && counter_step && counter_value == 16'h0000)
                        chan_pin_out <= els == timer_channel_pkg::ELS_10;
                end
                timer_channel_pkg::MODE_CENTER_ALIGNED_PWM: begin
                    if (match && count_up)
                        chan_pin_out <= els != timer_channel_pkg::ELS_10;
                    else if (match)
                        chan_pin_out <= els == timer_channel_pkg::ELS_10;
                end
                default: chan_pin_out <= chan_pin_out;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            channel_event_flag <= 1'b0;
        else
            channel_event_flag <= sc_q[timer_channel_pkg::SC_FLAG_BIT];
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_pin_released: assert property (els == timer_channel_pkg::ELS_OFF |=> !chan_pin_oe)
        else $error("pin driven while edge/level select is off");
    a_capture_takes_count: assert property (cap_edge |=> value_q == $past(counter_value))
        else $error("capture did not store the counter");
    a_capture_edge_sel: assert property (mode == timer_channel_pkg::MODE_CAPTURE &&
        els == timer_channel_pkg::ELS_01 && pin_fall && !pin_rise |-> !event_hit)
        else $error("falling edge captured with rising-only select");
    a_compare_toggle: assert property (mode == timer_channel_pkg::MODE_COMPARE &&
        els == timer_channel_pkg::ELS_01 && match |=> chan_pin_out != $past(chan_pin_out))
        else $error("compare toggle missing");
    a_capture_no_write: assert property (mode == timer_channel_pkg::MODE_CAPTURE &&
        !cap_edge && (wr_vh || wr_vl) |=> $stable(value_q))
        else $error("value written in capture mode");
    a_flag_on_event: assert property (event_hit |=> sc_q[timer_channel_pkg::SC_FLAG_BIT]
        ##1 channel_event_flag)
        else $error("event flag not set");
    a_noclk_load: assert property (seq_done && !clk_on && !cap_edge |=>
        value_q == $past(wbuf_d))
        else $error("unclocked buffered load missing");
    a_sc_clears_latch: assert property (wr_sc |=> !rd_latched_q && !wr_hi_seen_q &&
        !wr_lo_seen_q && !xfer_pend_q)
        else $error("status write left a latch set");
    a_debug_live_read: assert property (rd_val && rd_is_hi && debug |=>
        hrdata[7:0] == $past(value_q[15:8]))
        else $error("debug read returned buffered copy");
    a_debug_keeps_seq: assert property (debug && !wr_sc |=> $stable(wr_hi_seen_q) &&
        $stable(rd_latched_q))
        else $error("debug access disturbed a sequence");
    a_pwm_period_load: assert property (xfer_now && mode == timer_channel_pkg::MODE_EDGE_ALIGNED_PWM &&
        !(wr_val && debug) |-> counter_value == counter_top ##1 value_q == $past(wbuf_q))
        else $error("pwm buffered load at wrong count");

    c_capture: cover property (cap_edge ##1 rd_val ##[1:20] rd_val);
    c_compare_load: cover property (seq_done && clk_on ##[1:200] xfer_now);
    c_pwm_cycle: cover property (mode == timer_channel_pkg::MODE_EDGE_ALIGNED_PWM && match ##[1:500] match);
    c_flag_clear: cover property (flag_armed_q ##[1:10] wr_sc);
endmodule // timer_channel

// File: test/cpu_bus_model.sv
module cpu_bus_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [7:0]       haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    bit hung = 1'b0;

    initial begin
        hsel   = 1'b0;
        haddr  = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // bounded so a dead slave ends the run instead of hanging it
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1)
            hung = 1'b1;
    endtask

    // called just after a rising edge; single word transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_ready();
        q = hrdata[7:0];
    endtask
endmodule // cpu_bus_model

// File: test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hready, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans, clock_select = 2'h0;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic [15:0] counter_value = 16'h0000;
    logic [15:0] modulo_value = 16'h0000;
    logic        counter_step = 1'b0;
    logic        count_up = 1'b1;
    logic        center_aligned_select = 1'b0;
    logic        background_debug_mode = 1'b0;
    logic        chan_pin_in = 1'b0;
    logic        chan_pin_out, chan_pin_oe, channel_event_flag;
    int          fail_count = 0;
    int          checks = 0;

    always #5 hclk = ~hclk;

    cpu_bus_model cpu (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);

    timer_channel i_timer_channel (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout(hready), .hresp, .hrdata, .counter_value, .counter_step, .count_up,
        .clock_select, .modulo_value, .center_aligned_select, .background_debug_mode,
        .chan_pin_in, .chan_pin_out, .chan_pin_oe, .channel_event_flag);

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        cpu.xfer(w, a, d, q);
        if (cpu.hung) begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        xf(1'b1, a, d, q);
    endtask

    task automatic sc(input logic [7:0] d);
        wr(timer_channel_pkg::OFS_STATUS_CONTROL, d);
    endtask

    task automatic hi(input logic [7:0] d);
        wr(timer_channel_pkg::OFS_VALUE_HIGH, d);
    endtask

    task automatic lo(input logic [7:0] d);
        wr(timer_channel_pkg::OFS_VALUE_LOW, d);
    endtask

    task automatic rb(input logic [7:0] a, input logic [7:0] e, input string m);
        logic [7:0] q;
        xf(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, e}, m);
    endtask

    // high byte first, then low byte, each byte compared on its own
    task automatic rv(input logic [15:0] e, input string m);
        rb(timer_channel_pkg::OFS_VALUE_HIGH, e[15:8], m);
        rb(timer_channel_pkg::OFS_VALUE_LOW, e[7:0], m);
    endtask

    task automatic flag(input logic e, input string m);
        logic [7:0] q;
        xf(1'b0, timer_channel_pkg::OFS_STATUS_CONTROL, 8'h00, q);
        chk({15'h0000, q[7]}, {15'h0000, e}, m);
    endtask

    task automatic step(input logic [15:0] v);
        counter_value <= v;
        counter_step  <= 1'b1;
        @(posedge hclk);
        counter_step  <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask

    // pin held 8 cycles at each level, well past the sync delay
    task automatic edges(input logic [15:0] a, input logic [15:0] b);
        counter_value <= a;
        chan_pin_in   <= 1'b1;
        repeat (8) @(posedge hclk);
        counter_value <= b;
        chan_pin_in   <= 1'b0;
        repeat (8) @(posedge hclk);
    endtask

    task automatic t_reset();
        rv(16'h0000, "value after reset");
        rb(timer_channel_pkg::OFS_STATUS_CONTROL, 8'h00, "status after reset");
        rb(8'h0c, 8'h00, "unmapped read");
        chk({15'h0000, hresp}, 16'h0000, "okay response");
        $display("test reset done");
    endtask

    task automatic t_compare_noclk();
        sc(8'h1c);
        lo(8'h34);
        hi(8'h12);
        rv(16'h1234, "low first load");
        hi(8'h56);
        lo(8'h78);
        rv(16'h5678, "high first load");
        $display("test compare_noclk done");
    endtask

    task automatic t_pin();
        logic [7:0] cfg [4] = '{8'h1c, 8'h18, 8'h14, 8'h14};
        logic       exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        step(16'h5678);
        flag(1'b0, "no match without clock");
        clock_select <= 2'h1;
        for (int i = 0; i < 4; i++) begin
            flag(1'b1 & (i > 0), "flag before clear");
            sc(cfg[i]);
            step(16'h5678);
            chk({15'h0000, chan_pin_out}, {15'h0000, exp[i]}, "compare pin");
            chk({15'h0000, chan_pin_oe}, 16'h0001, "pin driven");
            flag(1'b1, "match flag");
        end
        sc(8'h10);
        repeat (2) @(posedge hclk);
        chk({15'h0000, chan_pin_oe}, 16'h0000, "pin released");
        $display("test pin done");
    endtask

    task automatic t_buffered();
        sc(8'h1c);
        hi(8'h00);
        lo(8'h20);
        rv(16'h5678, "held until step");
        step(16'h0001);
        rv(16'h0020, "loaded at step");
        $display("test buffered done");
    endtask

    task automatic t_pwm();
        modulo_value <= 16'h0100;
        sc(8'h28);
        hi(8'h00);
        lo(8'h40);
        step(16'h00ff);
        rv(16'h0020, "not loaded below top");
        step(16'h0100);
        rv(16'h0040, "loaded at top");
        step(16'h0000);
        chk({15'h0000, chan_pin_out}, 16'h0001, "pwm period start");
        step(16'h0040);
        chk({15'h0000, chan_pin_out}, 16'h0000, "pwm cleared on match");
        $display("test pwm done");
    endtask

    task automatic t_debug();
        clock_select <= 2'h0;
        sc(8'h1c);
        hi(8'haa);
        background_debug_mode <= 1'b1;
        hi(8'h01);
        lo(8'h02);
        rv(16'h0102, "debug direct write");
        background_debug_mode <= 1'b0;
        lo(8'hbb);
        rv(16'haabb, "partial sequence kept");
        hi(8'h99);
        sc(8'h1c);
        lo(8'h77);
        rv(16'haabb, "sequence restarted");
        hi(8'h11);
        rv(16'h1177, "new sequence done");
        $display("test debug done");
    endtask

    task automatic t_capture();
        sc(8'h0c);
        hi(8'h55);
        lo(8'h66);
        rv(16'h1177, "capture ignores writes");
        edges(16'h1122, 16'h1122);
        rb(timer_channel_pkg::OFS_VALUE_HIGH, 8'h11, "capture high");
        edges(16'h3344, 16'h3344);
        rb(timer_channel_pkg::OFS_VALUE_LOW, 8'h22, "buffered low");
        rv(16'h3344, "fresh capture");
        flag(1'b1, "capture flag");
        rb(timer_channel_pkg::OFS_VALUE_HIGH, 8'h33, "latch high");
        edges(16'h5566, 16'h5566);
        sc(8'h0c);
        rb(timer_channel_pkg::OFS_VALUE_LOW, 8'h66, "latch released");
        rb(timer_channel_pkg::OFS_VALUE_HIGH, 8'h55, "latch released");
        background_debug_mode <= 1'b1;
        rb(timer_channel_pkg::OFS_VALUE_HIGH, 8'h55, "debug read");
        edges(16'h7788, 16'h7788);
        rb(timer_channel_pkg::OFS_VALUE_LOW, 8'h88, "debug live read");
        background_debug_mode <= 1'b0;
        sc(8'h04);
        edges(16'h0101, 16'h0202);
        rv(16'h0101, "rising only");
        sc(8'h08);
        edges(16'h0303, 16'h0404);
        rv(16'h0404, "falling only");
        $display("test capture done");
    endtask

    // centre mode with the clock off loads at once; direction picks the pin level
    task automatic t_center_aligned_pwm();
        center_aligned_select <= 1'b1;
        sc(8'h08);
        hi(8'h00);
        lo(8'h30);
        clock_select <= 2'h1;
        count_up     <= 1'b0;
        step(16'h0030);
        chk({15'h0000, chan_pin_out}, 16'h0001, "centre down match sets");
        count_up <= 1'b1;
        step(16'h0030);
        chk({15'h0000, chan_pin_out}, 16'h0000, "centre up match clears");
        chk({15'h0000, chan_pin_oe}, 16'h0001, "centre pin driven");
        chk({15'h0000, channel_event_flag}, 16'h0001, "flag output");
        $display("test center_aligned_pwm done");
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset();
        t_compare_noclk();
        t_pin();
        t_buffered();
        t_pwm();
        t_debug();
        t_capture();
        t_center_aligned_pwm();
        wrap_up();
    end
endmodule // testbench
